// >>> logic/lexs_pkg.sv
/*
  lexs_pkg: constants shared by the serial LED expander slave, its
  checks and its bench. Assumes the 100 MHz system clock.
*/
package lexs_pkg;

  // pins and register file
  localparam int          NUM_PINS      = 16;
  localparam int          NUM_BLINK     = 2;
  localparam int          REG_NUM       = 10;
  localparam logic [3:0]  REG_INPUT0    = 4'h0;
  localparam logic [3:0]  REG_INPUT1    = 4'h1;
  localparam logic [3:0]  REG_PSC0      = 4'h2;
  localparam logic [3:0]  REG_DUTY0     = 4'h3;
  localparam logic [3:0]  REG_PSC1      = 4'h4;
  localparam logic [3:0]  REG_DUTY1     = 4'h5;
  localparam logic [3:0]  REG_SEL0      = 4'h6;
  localparam logic [3:0]  REG_LAST      = 4'h9;
  localparam int          PINS_PER_SEL  = 4;

  // command byte layout
  localparam int          CMD_AI_BIT    = 4;
  localparam int          CMD_PTR_MSB   = 3;

  // pin selector codes
  localparam logic [1:0]  SEL_HIZ       = 2'h0;
  localparam logic [1:0]  SEL_LOW       = 2'h1;
  localparam logic [1:0]  SEL_BLINK0    = 2'h2;
  localparam logic [1:0]  SEL_BLINK1    = 2'h3;

  // reset values
  localparam logic [7:0]  RST_PSC       = 8'h97;
  localparam logic [7:0]  RST_DUTY      = 8'h80;
  localparam logic [7:0]  RST_SEL       = 8'h00;

  // slave address: upper four bits fixed, lower three from straps
  localparam logic [3:0]  ADDR_HI       = 4'hc;
  localparam int          BITS_PER_BYTE = 8;

  // blink time base: one step of each blink counter
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          BLINK_STEP_US = 1000;
  localparam int          BLINK_STEP_CYC =
    (BLINK_STEP_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ADDR  = 3'h1,
    ST_ACK   = 3'h3,
    ST_WDATA = 3'h2,
    ST_RDATA = 3'h6,
    ST_RACK  = 3'h7,
    ST_WAIT  = 3'h5
  } lexs_state_t;

endpackage

// >>> logic/lexs_buf.sv
/*
  lexs_buf: two-entry buffer with valid/ready on both sides and a
  synchronous flush. Read data comes out of a register-backed entry.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module lexs_buf #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic [W-1:0] mem_r [2];
  logic         wr_ptr_r;
  logic         rd_ptr_r;
  logic [1:0]   count_r;
  logic         push;
  logic         pop;

  assign in_ready  = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk_sys)
  begin
    if (rst || flush)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= ~wr_ptr_r;
      if (pop)
        rd_ptr_r <= ~rd_ptr_r;
      case ({push, pop})
        2'b10:   count_r <= count_r + 2'h1;
        2'b01:   count_r <= count_r - 2'h1;
        default: count_r <= count_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data;
  end

endmodule // lexs_buf

// >>> logic/lexs_top.sv
/*
  lexs_top: two-wire serial slave and register path of a 16-pin LED
  driver / port expander, with pin selectors and two blink generators.
  Assumes scl/sda inputs already synchronous to clk_sys; open-drain
  wires are resolved outside from the output enables.
*/
`timescale 1ns/1ps
module lexs_top
  import lexs_pkg::*;
#(
  parameter int BLINK_STEP = lexs_pkg::BLINK_STEP_CYC
) (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          ext_reset_n,
  input  wire logic                          por_active,
  input  wire logic                          address_strap_0,
  input  wire logic                          address_strap_1,
  input  wire logic                          address_strap_2,
  input  wire logic                          scl_i,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe,
  input  wire logic [lexs_pkg::NUM_PINS-1:0] driver_pins_i,
  output logic      [lexs_pkg::NUM_PINS-1:0] driver_pins_o,
  output logic      [lexs_pkg::NUM_PINS-1:0] driver_pins_oe
);
  import lexs_pkg::*;

  lexs_state_t          state_r;
  logic                 rst_all;
  logic                 scl_q_r, sda_q_r;
  logic                 start_ev, stop_ev, scl_rise, scl_fall, byte_done;
  logic [3:0]           bitcnt_r, ptr_r, fetch_ptr_r;
  logic [7:0]           shift_r, tx_r;
  logic                 rw_r, cmd_seen_r, ai_r, mack_r;
  logic                 sda_oe_r, sda_o_r;
  logic [7:0]           regs_r [REG_NUM];
  logic                 wr_stb, cap_stb, pop_stb, fetch_en;
  logic                 buf_in_ready, buf_out_valid;
  logic [7:0]           buf_out_data, fetch_data;
  logic                 addr_hit;
  logic [NUM_PINS-1:0]  pin_oe_r, pin_o_r;
  logic [31:0]          step_cnt_r;
  logic                 step_r;
  logic [7:0]           blink_cnt_r [NUM_BLINK];
  logic [NUM_BLINK-1:0] blink_on_r;

  // external reset pin folded into the synchronous reset
  // power-on indication holds everything in reset
  assign rst_all = rst | ~ext_reset_n | por_active;

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = (p >= REG_LAST) ? 4'h0 : p + 4'h1;
  endfunction

  function automatic logic [7:0] reg_reset(input int idx);
    if (idx == int'(REG_PSC0) || idx == int'(REG_PSC1))
      reg_reset = RST_PSC;
    else if (idx == int'(REG_DUTY0) || idx == int'(REG_DUTY1))
      reg_reset = RST_DUTY;
    else
      reg_reset = RST_SEL;
  endfunction

  // line sampling; inputs are synchronous, so one stage suffices
  // reset parks the samplers at the idle level, so no false edge follows
  always_ff @(posedge clk_sys)
  begin
    scl_q_r <= rst_all | scl_i;
    sda_q_r <= rst_all | sda_i;
  end

  assign start_ev  = scl_q_r & scl_i & sda_q_r & ~sda_i;
  assign stop_ev   = scl_q_r & scl_i & ~sda_q_r & sda_i;
  assign scl_rise  = ~scl_q_r & scl_i;
  assign scl_fall  = scl_q_r & ~scl_i;
  assign byte_done = scl_fall & (bitcnt_r == 4'(BITS_PER_BYTE));

  // low address bits from the straps
  assign addr_hit = (shift_r[7:1] == {ADDR_HI, address_strap_2,
                                      address_strap_1, address_strap_0});

  assign wr_stb   = (state_r == ST_WDATA) & byte_done & cmd_seen_r;
  // input capture on the falling edge of every acknowledge clock
  assign cap_stb  = scl_fall & ((state_r == ST_ACK) | (state_r == ST_RACK));
  // next byte is taken only after an acknowledge
  assign pop_stb  = scl_fall & (((state_r == ST_ACK) & rw_r) |
                                ((state_r == ST_RACK) & mack_r));
  assign fetch_en = rw_r & ((state_r == ST_ACK) | (state_r == ST_RDATA) |
                            (state_r == ST_RACK));
  assign fetch_data = (fetch_ptr_r <= REG_LAST) ? regs_r[fetch_ptr_r]
                                                : 8'h00;

  // serial protocol state machine
  always_ff @(posedge clk_sys)
  begin
    if (rst_all)
    begin
      state_r    <= ST_IDLE;
      bitcnt_r   <= 4'h0;
      shift_r    <= 8'h00;
      tx_r       <= 8'hff;
      rw_r       <= 1'b0;
      cmd_seen_r <= 1'b0;
      ai_r       <= 1'b0;
      mack_r     <= 1'b0;
      ptr_r      <= 4'h0;
      sda_oe_r   <= 1'b0;
    end
    else if (start_ev)
    begin
      state_r    <= ST_ADDR;
      bitcnt_r   <= 4'h0;
      cmd_seen_r <= 1'b0;
      rw_r       <= 1'b0;
      sda_oe_r   <= 1'b0;
    end
    else if (stop_ev)
    begin
      // stop returns the slave to standby
      state_r  <= ST_IDLE;
      rw_r     <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        ST_ADDR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_r  <= {shift_r[6:0], sda_i};
            bitcnt_r <= bitcnt_r + 4'h1;
          end
          else if (byte_done)
          begin
            if (state_r == ST_ADDR)
            begin
              if (addr_hit)
              begin
                rw_r     <= shift_r[0];
                state_r  <= ST_ACK;
                sda_oe_r <= 1'b1;
              end
              else
                state_r <= ST_WAIT;
            end
            else
            begin
              // first written byte is the command
              if (!cmd_seen_r)
              begin
                cmd_seen_r <= 1'b1;
                ptr_r      <= shift_r[CMD_PTR_MSB:0];
                ai_r       <= shift_r[CMD_AI_BIT];
              end
              else if (ai_r)
                ptr_r <= ptr_inc(ptr_r);
              state_r  <= ST_ACK;
              sda_oe_r <= 1'b1;
            end
          end
        end
        ST_ACK:
        begin
          // low held from one scl fall to the next
          if (scl_fall)
          begin
            bitcnt_r <= 4'h0;
            if (rw_r)
            begin
              tx_r     <= buf_out_valid ? buf_out_data : 8'hff;
              sda_oe_r <= buf_out_valid & ~buf_out_data[7];
              state_r  <= ST_RDATA;
            end
            else
            begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_WDATA;
            end
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            bitcnt_r <= bitcnt_r + 4'h1;
            // release the line after the eighth bit
            if (bitcnt_r == 4'(BITS_PER_BYTE - 1))
            begin
              sda_oe_r <= 1'b0;
              state_r  <= ST_RACK;
            end
            else
            begin
              tx_r     <= {tx_r[6:0], 1'b1};
              sda_oe_r <= ~tx_r[6];
            end
          end
        end
        ST_RACK:
        begin
          // sample master acknowledge on the ninth rise
          if (scl_rise)
            mack_r <= ~sda_i;
          else if (scl_fall)
          begin
            bitcnt_r <= 4'h0;
            if (mack_r)
            begin
              tx_r     <= buf_out_valid ? buf_out_data : 8'hff;
              sda_oe_r <= buf_out_valid & ~buf_out_data[7];
              state_r  <= ST_RDATA;
            end
            else
              state_r <= ST_WAIT;
          end
        end
        ST_IDLE, ST_WAIT:
          sda_oe_r <= 1'b0;
        default:
        begin
          state_r  <= ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // read prefetch pointer: copies the command pointer at each start
  always_ff @(posedge clk_sys)
  begin
    if (rst_all)
      fetch_ptr_r <= 4'h0;
    else if (start_ev)
      fetch_ptr_r <= ptr_r;
    // walk registers only with auto-increment set
    else if (fetch_en && buf_in_ready && ai_r)
      fetch_ptr_r <= ptr_inc(fetch_ptr_r);
  end

  // flushed on start/stop so a new read never sees stale bytes
  lexs_buf #(.W (8)) u_rdbuf (
    .clk_sys   (clk_sys),
    .rst       (rst_all),
    .flush     (start_ev | stop_ev),
    .in_valid  (fetch_en),
    .in_ready  (buf_in_ready),
    .in_data   (fetch_data),
    .out_valid (buf_out_valid),
    .out_ready (pop_stb),
    .out_data  (buf_out_data)
  );

  // register file; input registers are never written from the bus
  always_ff @(posedge clk_sys)
  begin
    if (rst_all)
    begin
      for (int i = 0; i < REG_NUM; i++)
        regs_r[i] <= reg_reset(i);
    end
    else
    begin
      // input registers follow pins regardless of selector
      if (cap_stb)
      begin
        regs_r[REG_INPUT0] <= driver_pins_i[7:0];
        regs_r[REG_INPUT1] <= driver_pins_i[15:8];
      end
      if (wr_stb && ptr_r >= REG_PSC0 && ptr_r <= REG_LAST)
        regs_r[ptr_r] <= shift_r;
    end
  end

  // blink time base divider
  always_ff @(posedge clk_sys)
  begin
    if (rst_all || step_cnt_r >= 32'(BLINK_STEP - 1))
      step_cnt_r <= 32'h0;
    else
      step_cnt_r <= step_cnt_r + 32'h1;
    step_r <= ~rst_all & (step_cnt_r >= 32'(BLINK_STEP - 1));
  end

  // two independent blink generators, period and duty from regs
  for (genvar g = 0; g < NUM_BLINK; g++)
  begin : g_blink
    localparam logic [3:0] PSC_IDX  = REG_PSC0 + 4'(2 * g);
    localparam logic [3:0] DUTY_IDX = REG_DUTY0 + 4'(2 * g);
    always_ff @(posedge clk_sys)
    begin
      if (rst_all)
      begin
        blink_cnt_r[g] <= 8'h00;
        blink_on_r[g]  <= 1'b0;
      end
      else
      begin
        if (step_r)
          blink_cnt_r[g] <= (blink_cnt_r[g] >= regs_r[PSC_IDX]) ? 8'h00
                            : blink_cnt_r[g] + 8'h01;
        blink_on_r[g] <= (blink_cnt_r[g] < regs_r[DUTY_IDX]);
      end
    end
  end

  // sixteen pins, each with its own selector field
  always_ff @(posedge clk_sys)
  begin
    pin_o_r <= '0;
    sda_o_r <= 1'b0;
    if (rst_all)
      pin_oe_r <= '0;
    else
    begin
      for (int i = 0; i < NUM_PINS; i++)
      begin
        case (regs_r[REG_SEL0 + 4'(i / PINS_PER_SEL)]
                    [(i % PINS_PER_SEL) * 2 +: 2])
          SEL_HIZ:    pin_oe_r[i] <= 1'b0;
          SEL_LOW:    pin_oe_r[i] <= 1'b1;
          SEL_BLINK0: pin_oe_r[i] <= blink_on_r[0];
          SEL_BLINK1: pin_oe_r[i] <= blink_on_r[1];
          default:    pin_oe_r[i] <= 1'b0;
        endcase
      end
    end
  end

  assign driver_pins_o  = pin_o_r;
  assign driver_pins_oe = pin_oe_r;
  assign sda_o          = sda_o_r;
  assign sda_oe         = sda_oe_r;

endmodule // lexs_top

// >>> sim/lexs_top_assertions.sv
/*
  lexs_top_chk: port-level checks of the serial slave and pin drivers.
  Assumes one clock, synchronous active-high rst, bound into lexs_top.
*/
`timescale 1ns/1ps
module lexs_top_chk
  import lexs_pkg::*;
#(
  parameter int BLINK_STEP = 4
) (
  input wire logic                          clk_sys,
  input wire logic                          rst,
  input wire logic                          ext_reset_n,
  input wire logic                          por_active,
  input wire logic                          scl_i,
  input wire logic                          sda_i,
  input wire logic                          sda_o,
  input wire logic                          sda_oe,
  input wire logic [lexs_pkg::NUM_PINS-1:0] driver_pins_o,
  input wire logic [lexs_pkg::NUM_PINS-1:0] driver_pins_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_start;
    scl_i && $past(scl_i) && $fell(sda_i);
  endsequence

  sequence s_stop;
    scl_i && $past(scl_i) && $rose(sda_i);
  endsequence

  a_ack_stable: assert property (scl_i |=> $stable(sda_oe))
    else $error("sda drive moved while clock high");
  a_change_low: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i))
    else $error("sda drive changed outside clock low");
  a_stop_idle: assert property (s_stop |=> !sda_oe [*4])
    else $error("sda driven after stop");
  a_start_free: assert property (s_start |=> !sda_oe)
    else $error("sda driven right after start");
  a_sda_o_zero: assert property (sda_o == 1'h0)
    else $error("sda output not open drain");
  a_pins_o_zero: assert property (driver_pins_o == '0)
    else $error("pin output not open drain");
  a_ext_reset: assert property (!ext_reset_n |=> !sda_oe && driver_pins_oe == '0)
    else $error("outputs active after external reset");
  a_por_hold: assert property (por_active |=> !sda_oe && driver_pins_oe == '0)
    else $error("outputs active during power-on reset");
endmodule // lexs_top_chk

bind lexs_top lexs_top_chk #(.BLINK_STEP(BLINK_STEP)) u_chk (
  .clk_sys        (clk_sys),
  .rst            (rst),
  .ext_reset_n    (ext_reset_n),
  .por_active     (por_active),
  .scl_i          (scl_i),
  .sda_i          (sda_i),
  .sda_o          (sda_o),
  .sda_oe         (sda_oe),
  .driver_pins_o  (driver_pins_o),
  .driver_pins_oe (driver_pins_oe)
);

// >>> sim/lexs_bus_mst.sv
/*
  lexs_bus_mst: behavioural two-wire bus master driving the clock line
  and pulling the data line. Assumes a pulled-up wire resolved outside.
*/
`timescale 1ns/1ps
module lexs_bus_mst (
  input  wire logic clk_sys,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_dn
);
  // raise for a slow master; each phase lasts half_n cycles
  int half_n = 5;

  initial
  begin
    scl = 1'h1;
    sda_dn = 1'h0;
  end

  task automatic half();
    repeat (half_n) @(posedge clk_sys);
  endtask

  task automatic start_c();
    sda_dn <= 1'h0;
    half();
    scl <= 1'h1;
    half();
    sda_dn <= 1'h1;
    half();
    scl <= 1'h0;
    half();
  endtask

  task automatic stop_c();
    sda_dn <= 1'h1;
    half();
    scl <= 1'h1;
    half();
    sda_dn <= 1'h0;
    half();
  endtask

  // ninth bit ack: tx[0]=0 pulls low through the high phase
  task automatic byte_x(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--)
    begin
      sda_dn <= ~tx[i];
      half();
      scl <= 1'h1;
      half();
      rx[i] = sda;
      scl <= 1'h0;
      half();
    end
  endtask
endmodule // lexs_bus_mst

// >>> sim/tb_top.sv
/*
  tb_top: directed bench for lexs_top with a bus master model.
  Assumes lexs_pkg constants and a pulled-up open-drain bus and pins.
*/
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    tests_run++; \
    if ((a) !== (e)) \
    begin \
      bad_count++; \
      $display("[ERR] %0t got %h want %h", $time, a, e); \
    end \
  end
module tb_top;
  import lexs_pkg::*;
  localparam logic [6:0] DEV = {ADDR_HI, 3'h5};
  logic        clk_sys;
  logic        rst;
  logic        ext_reset_n;
  logic        por_active;
  logic [2:0]  strap;
  logic [15:0] pin_ext;
  logic        scl;
  logic        mst_dn;
  logic        sda_o;
  logic        sda_oe;
  logic [15:0] pins_o;
  logic [15:0] pins_oe;
  wire         sda = ~(mst_dn | sda_oe);
  wire  [15:0] pins_i = pin_ext & ~pins_oe;
  int          bad_count;
  int          tests_run;

  lexs_top #(.BLINK_STEP(4)) DUT (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .ext_reset_n     (ext_reset_n),
    .por_active      (por_active),
    .address_strap_0 (strap[0]),
    .address_strap_1 (strap[1]),
    .address_strap_2 (strap[2]),
    .scl_i           (scl),
    .sda_i           (sda),
    .sda_o           (sda_o),
    .sda_oe          (sda_oe),
    .driver_pins_i   (pins_i),
    .driver_pins_o   (pins_o),
    .driver_pins_oe  (pins_oe)
  );

  lexs_bus_mst mst (
    .clk_sys (clk_sys),
    .sda     (sda),
    .scl     (scl),
    .sda_dn  (mst_dn)
  );

  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic head(input logic [7:0] cmd);
    logic [8:0] rx;
    mst.start_c();
    mst.byte_x({DEV, 1'h0, 1'h1}, rx);
    `CHK(rx[0], 1'h0)
    mst.byte_x({cmd, 1'h1}, rx);
    `CHK(rx[0], 1'h0)
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d[$]);
    logic [8:0] rx;
    head(cmd);
    foreach (d[i])
    begin
      mst.byte_x({d[i], 1'h1}, rx);
      `CHK(rx[0], 1'h0)
    end
    mst.stop_c();
  endtask

  // last byte gets no ack from the master
  task automatic rd(input logic [7:0] cmd, input logic [7:0] e[$]);
    logic [8:0] rx;
    head(cmd);
    mst.start_c();
    mst.byte_x({DEV, 1'h1, 1'h1}, rx);
    `CHK(rx[0], 1'h0)
    foreach (e[i])
    begin
      mst.byte_x({8'hff, i == e.size() - 1}, rx);
      `CHK(rx[8:1], e[i])
    end
    `CHK(sda_oe, 1'h0)
    mst.stop_c();
  endtask

  task automatic sc_access();
    wr(8'h16, '{8'h54, 8'h01});
    repeat (3) @(posedge clk_sys);
    `CHK(pins_oe[4:0], 5'h1e)
    `CHK(pins_oe[15:5], 11'h0)
    rd(8'h16, '{8'h54, 8'h01});
  endtask

  // driven-low pins 1..4 read back low, the rest follow the outside level
  task automatic sc_inputs();
    pin_ext <= 16'ha5c3;
    rd(8'h10, '{8'hc1, 8'ha5});
  endtask

  task automatic sc_bad_addr();
    logic [8:0] rx;
    mst.start_c();
    mst.byte_x({ADDR_HI, 3'h4, 1'h0, 1'h1}, rx);
    `CHK(rx[0], 1'h1)
    mst.stop_c();
  endtask

  // whole periods only, so the count is phase independent
  task automatic sc_blink();
    int on0;
    int on1;
    on0 = 0;
    on1 = 0;
    wr(8'h12, '{8'h01, 8'h01, 8'h03, 8'h01, 8'h0e});
    repeat (8) @(posedge clk_sys);
    `CHK(pins_oe[3:2], 2'h0)
    repeat (64)
    begin
      @(posedge clk_sys);
      on0 += pins_oe[0];
      on1 += pins_oe[1];
    end
    `CHK(on0, 32)
    `CHK(on1, 16)
  endtask

  task automatic sc_reset();
    ext_reset_n <= 1'h0;
    @(posedge clk_sys);
    ext_reset_n <= 1'h1;
    repeat (3) @(posedge clk_sys);
    `CHK(pins_oe, 16'h0)
    mst.half_n = 9;
    rd(8'h12, '{RST_PSC, RST_DUTY, RST_PSC, RST_DUTY, RST_SEL});
    wr(8'h09, '{8'h40});
    repeat (3) @(posedge clk_sys);
    `CHK(pins_oe[15], 1'h1)
    por_active <= 1'h1;
    repeat (2) @(posedge clk_sys);
    por_active <= 1'h0;
    repeat (3) @(posedge clk_sys);
    `CHK(pins_oe, 16'h0)
    rd(8'h09, '{8'h00});
  endtask

  initial
  begin
    rst = 1'h1;
    ext_reset_n = 1'h1;
    por_active = 1'h0;
    strap = 3'h5;
    pin_ext = 16'hffff;
    bad_count = 0;
    tests_run = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    repeat (4) @(posedge clk_sys);
    sc_access();
    sc_inputs();
    sc_bad_addr();
    sc_blink();
    sc_reset();
    final_report();
  end

  // about three times the expected run length
  initial
  begin
    repeat (24000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end
endmodule // tb_top
